// ===== hdl/efsup_pkg.sv
// Constants and carrier types for the fuse fault and sync supervisor
// How it works
// [R1] Health failure pulls gate low, latches fault
// [R2] Drain short at start: discharge, timer, fault
// [R3] Gate near input while off flags gate-drain short
// [R4] No overdrive before startup timeout flags short
// [R5] Overdrive loss after inrush latches fault immediately
// [R6] Thermal shutdown on absolute or relative threshold
// [R7] Latch-off variant stays off until power/enable cycle
// [R8] Auto-retry waits retry delay, retries if enabled
// [R9] Primary latches faults; restart uses slew-limited ramp
// [R10] Secondary short: fast trip, restart, fault output high
// [R11] Secondary pulls line low, waits, releases, samples
// [R12] Line still low: clear fault, follow primary
// [R13] Primary holds line low within the wait
// [R14] Failed handshake latches until power/enable cycle
// [R15] Power/enable cycle clears fault and retry timer
// [R16] Enable just below undervoltage keeps latched fault
// [R17] Release line to conduct; low line forces off
// [R18] Hold line low during listed off states
// [R19] Long low line clears fast-recovery flag
// [R20] External line pull-down is a latched fault
// [R21] Forced timer pin plus overcurrent latches after backup
// [R22] System pulls the line up externally
// [R23] Mode input sampled once after power-up
// [R24] Comparators arrive as bits; timers are counters
package efsup_pkg;

	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned HANDSHAKE_US = 10;
	localparam int unsigned HANDSHAKE_CYC = (HANDSHAKE_US * (CLK_HZ / 1_000_000) > 0) ?
		HANDSHAKE_US * (CLK_HZ / 1_000_000) : 1;
	localparam int unsigned CNT_W = 24;

	typedef struct packed {
		logic en_above_uvlo;    // Enable above undervoltage lockout
		logic en_above_sd;      // Enable above shutdown threshold
		logic supply_ok;        // Supply above undervoltage threshold
		logic over_voltage;     // Input overvoltage
		logic insertion_delay;  // Insertion delay still running
	} efsup_supply_t;

	typedef struct packed {
		logic vds_below_dsok;   // Drain-source below drain-ok threshold
		logic vout_below_fb;    // Output below foldback threshold
		logic gate_near_vin;    // Gate close to input voltage
		logic gate_overdrive_ok; // Gate overdrive reached
		logic tj_over_tsd;      // Junction at shutdown threshold
		logic tj_below_exit;    // Junction below threshold minus hysteresis
		logic rel_over;         // Gradient at relative threshold
		logic rel_below;        // Gradient below relative threshold
		logic fast_trip;        // Short-circuit comparator
		logic cb_trip;          // Circuit-breaker trip
		logic ilim_fault;       // Current-limit pin fault
		logic timer_pin_high;   // Overcurrent timer pin forced high
		logic over_ocp;         // Current above circuit-breaker level
		logic over_backup;      // Current above backup threshold
	} efsup_sense_t;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_DS_CHECK,
		ST_INRUSH,
		ST_ON,
		ST_TSD,
		ST_RETRY,
		ST_HANDSHAKE,
		ST_LATCHED
	} efsup_state_t;

endpackage

// ===== hdl/efsup_core.sv
// Fault supervisor and shared switch-enable logic for the fuse
`timescale 1ns/1ps
`default_nettype none
module efsup_core #(
	parameter bit AUTO_RETRY = 1'b0,
	parameter int unsigned DS_TMR_CYC = 100_000,
	parameter int unsigned SU_TMR_CYC = 100_000,
	parameter int unsigned RETRY_CYC = 1_000_000,
	parameter int unsigned SHARED_SWITCH_ENABLE_TO_CYC = 50_000,
	parameter int unsigned BKP_TMR_CYC = 100_000
) (
	input wire logic i_ref_clk,                       // 10 MHz clock
	input wire logic i_sys_rst,                       // Async reset, high
	input wire logic i_mode_secondary,                // Mode pin grounded
	input wire efsup_pkg::efsup_supply_t i_supply,    // Supply and enable states
	input wire efsup_pkg::efsup_sense_t i_sense,      // Comparator results
	input wire logic i_shared_switch_enable,          // Shared line level
	output logic o_shared_switch_enable,              // Line output (unused low)
	output logic o_shared_switch_enable_oe,           // Pull line low
	output logic o_gate_on,                           // Gate driver on
	output logic o_output_discharge,                  // Output discharge on
	output logic o_fault_out_n,                       // Fault output level
	output logic o_fault_out_n_oe,                    // Pull fault output low
	output logic o_fast_recovery_flag,                // Fast restart allowed
	output logic o_thermal_shutdown,                  // Thermal shutdown active
	output logic o_secondary_mode,                    // Sampled mode
	output logic o_fault_latched                      // Internal fault latched
);
	import efsup_pkg::*;

	// Refuses timer counts that the counters cannot hold
	if (DS_TMR_CYC < 1 || SU_TMR_CYC < 1 || RETRY_CYC < 1 || SHARED_SWITCH_ENABLE_TO_CYC < 1 ||
		BKP_TMR_CYC < 1 || DS_TMR_CYC >= (1 << CNT_W) || SU_TMR_CYC >= (1 << CNT_W) ||
		RETRY_CYC >= (1 << CNT_W) || SHARED_SWITCH_ENABLE_TO_CYC >= (1 << CNT_W) ||
		BKP_TMR_CYC >= (1 << CNT_W)) begin : g_bad_timer
		$error("efsup_core: timer count out of range");
	end

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	localparam int unsigned SYN_W = $bits(efsup_supply_t) + $bits(efsup_sense_t) + 2;
	logic [SYN_W-1:0] sync1_q;
	logic [SYN_W-1:0] sync2_q;

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin  // R24
		if (i_sys_rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {i_supply, i_sense, i_shared_switch_enable, i_mode_secondary};
			sync2_q <= sync1_q;
		end
	end

	efsup_supply_t sup;
	efsup_sense_t sns;
	wire logic line_hi;
	wire logic mode_pin;
	assign {sup, sns, line_hi, mode_pin} = sync2_q;

	// ------------------------------------------------------------
	// Mode capture after reset release
	// ------------------------------------------------------------
	logic [1:0] mode_wait_q;
	logic mode_taken_q;
	logic secondary_q;

	// Waits until the pin has passed both synchroniser stages
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin  // R23
		if (i_sys_rst) begin
			mode_wait_q <= 2'h0;
			mode_taken_q <= 1'b0;
			secondary_q <= 1'b0;
		end else if (!mode_taken_q) begin
			if (mode_wait_q == 2'h2) begin
				mode_taken_q <= 1'b1;
				secondary_q <= mode_pin;
			end else begin
				mode_wait_q <= mode_wait_q + 2'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	efsup_state_t state_q;
	efsup_state_t state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] low_cnt_q;
	logic [CNT_W-1:0] bkp_cnt_q;
	logic fast_recovery_flag_q;
	logic drive_low_q;
	logic fault_q;
	logic fault_d;
	logic flt_pin_q;
	logic flt_pin_d;
	logic drive_low_d;

	// A deep enable drop or a supply loss clears latched faults
	wire logic clear_cycle = !sup.en_above_sd || !sup.supply_ok;  // R15 R16
	wire logic uv_ov = !sup.en_above_uvlo || !sup.supply_ok || sup.over_voltage;
	wire logic enabled = mode_taken_q && !uv_ov && !sup.insertion_delay;
	wire logic tsd_enter = sns.tj_over_tsd || sns.rel_over;  // R6
	wire logic tsd_exit = sns.tj_below_exit && sns.rel_below;  // R6
	wire logic gd_short = sns.gate_near_vin && !o_gate_on;  // R3
	wire logic gs_steady = (state_q == ST_ON) && line_hi && !sns.gate_overdrive_ok;  // R5
	wire logic ext_low = !line_hi && !drive_low_q && !uv_ov && !secondary_q &&
		(state_q == ST_INRUSH || state_q == ST_ON);  // R20
	wire logic bkp_fault = sns.timer_pin_high && (bkp_cnt_q >= CNT_W'(BKP_TMR_CYC));  // R21
	wire logic conducting = (state_q == ST_INRUSH || state_q == ST_ON);
	wire logic hard_fault = gd_short || gs_steady || bkp_fault || ext_low ||
		(conducting && (sns.cb_trip || sns.ilim_fault));  // R1
	wire logic trip_fast = conducting && sns.fast_trip;
	wire logic cnt_done_ds = cnt_q >= CNT_W'(DS_TMR_CYC);
	wire logic cnt_done_su = cnt_q >= CNT_W'(SU_TMR_CYC);
	wire logic cnt_done_rt = cnt_q >= CNT_W'(RETRY_CYC);
	wire logic cnt_done_hs = cnt_q >= CNT_W'(HANDSHAKE_CYC);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d = (cnt_q == '1) ? cnt_q : cnt_q + CNT_W'(1);  // R24
		fault_d = fault_q;
		flt_pin_d = flt_pin_q;
		drive_low_d = 1'b1;
		if (clear_cycle) begin
			state_d = ST_OFF;
			cnt_d = '0;  // R15
			fault_d = 1'b0;
			flt_pin_d = 1'b0;
		end else if (tsd_enter && state_q != ST_LATCHED) begin
			state_d = ST_TSD;  // R6
			cnt_d = '0;
			fault_d = 1'b1;
			flt_pin_d = 1'b1;
		end else if (hard_fault && state_q != ST_LATCHED) begin
			state_d = ST_LATCHED;  // R1
			fault_d = 1'b1;
			flt_pin_d = 1'b1;
		end else if (trip_fast) begin
			cnt_d = '0;
			if (secondary_q) begin
				state_d = ST_HANDSHAKE;  // R10
				fault_d = 1'b1;
			end else begin
				state_d = ST_LATCHED;  // R9
				fault_d = 1'b1;
				flt_pin_d = 1'b1;
			end
		end else begin
			unique case (state_q)
				ST_OFF: begin
					cnt_d = '0;
					// Line is released once enabled so the chain can start together
					drive_low_d = !enabled;  // R18
					if (enabled && line_hi) begin
						state_d = sns.vds_below_dsok ? ST_DS_CHECK : ST_INRUSH;  // R2
					end
				end
				ST_DS_CHECK: begin
					drive_low_d = 1'b0;
					if (!enabled) begin
						state_d = ST_OFF;  // R18
					end else if (!sns.vds_below_dsok || sns.vout_below_fb) begin
						state_d = ST_INRUSH;
						cnt_d = '0;
					end else if (cnt_done_ds) begin
						state_d = ST_LATCHED;  // R2
						fault_d = 1'b1;
						flt_pin_d = 1'b1;
					end
				end
				ST_INRUSH: begin
					drive_low_d = 1'b0;
					if (!enabled || !line_hi) begin
						state_d = ST_OFF;  // R17
					end else if (sns.gate_overdrive_ok) begin
						state_d = ST_ON;
					end else if (cnt_done_su) begin
						state_d = ST_LATCHED;  // R4
						fault_d = 1'b1;
						flt_pin_d = 1'b1;
					end
				end
				ST_ON: begin
					drive_low_d = 1'b0;
					if (!enabled || !line_hi) begin
						state_d = ST_OFF;  // R17
					end
				end
				ST_TSD: begin
					cnt_d = '0;
					if (tsd_exit && AUTO_RETRY) begin
						state_d = ST_RETRY;  // R8
					end
				end
				ST_RETRY: begin
					if (cnt_done_rt) begin
						fault_d = 1'b0;
						flt_pin_d = 1'b0;
						state_d = ST_OFF;  // R8
					end
				end
				ST_HANDSHAKE: begin
					drive_low_d = !cnt_done_hs;  // R11
					if (cnt_q > CNT_W'(HANDSHAKE_CYC + 2)) begin
						if (line_hi) begin
							state_d = ST_LATCHED;  // R14
						end else begin
							fault_d = 1'b0;  // R12
							state_d = ST_OFF;
						end
					end
				end
				ST_LATCHED: begin
					cnt_d = '0;  // R7
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_q <= ST_OFF;
			cnt_q <= '0;
			fault_q <= 1'b0;
			flt_pin_q <= 1'b0;
			drive_low_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			fault_q <= fault_d;
			flt_pin_q <= flt_pin_d;
			drive_low_q <= drive_low_d;  // R18
		end
	end

	// ------------------------------------------------------------
	// Line-low timeout and backup overcurrent timer
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			low_cnt_q <= '0;
			fast_recovery_flag_q <= 1'b0;
			bkp_cnt_q <= '0;
		end else begin
			if (line_hi) begin
				low_cnt_q <= '0;
				if (state_q == ST_ON) begin
					fast_recovery_flag_q <= 1'b1;
				end
			end else if (low_cnt_q >= CNT_W'(SHARED_SWITCH_ENABLE_TO_CYC)) begin
				fast_recovery_flag_q <= 1'b0;  // R19
			end else begin
				low_cnt_q <= low_cnt_q + CNT_W'(1);
			end
			if (sns.timer_pin_high && (sns.over_ocp || sns.over_backup) && conducting) begin
				if (bkp_cnt_q != '1) begin
					bkp_cnt_q <= bkp_cnt_q + CNT_W'(1);  // R21
				end
			end else begin
				bkp_cnt_q <= '0;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_shared_switch_enable = 1'b0;
	assign o_shared_switch_enable_oe = drive_low_q;  // R18
	assign o_gate_on = conducting && line_hi && !drive_low_q;  // R17 R1
	assign o_output_discharge = (state_q == ST_DS_CHECK) && !sns.vout_below_fb &&
		!sns.tj_over_tsd;  // R2
	assign o_fault_out_n = 1'b0;
	assign o_fault_out_n_oe = flt_pin_q;  // R10
	assign o_fast_recovery_flag = fast_recovery_flag_q;
	assign o_thermal_shutdown = (state_q == ST_TSD);
	assign o_secondary_mode = secondary_q;
	assign o_fault_latched = fault_q;

endmodule
`default_nettype wire

// ===== verification/efsup_chk.sv
// Port assertions for the fuse supervisor
`timescale 1ns/1ps
`default_nettype none
module efsup_chk #(
	parameter bit AUTO_RETRY = 1'b0,
	parameter int unsigned SHARED_SWITCH_ENABLE_TO_CYC = 20
) (
	input wire logic i_ref_clk, // Clock
	input wire logic i_sys_rst, // Reset
	input wire efsup_pkg::efsup_supply_t i_supply, // Supply
	input wire efsup_pkg::efsup_sense_t i_sense, // Sense
	input wire logic i_shared_switch_enable, // Line
	input wire logic o_shared_switch_enable_oe, // Line pull
	input wire logic o_gate_on, // Gate
	input wire logic o_fault_out_n_oe, // Fault pull
	input wire logic o_fast_recovery_flag, // Fast flag
	input wire logic o_thermal_shutdown, // Thermal
	input wire logic o_secondary_mode, // Mode
	input wire logic o_fault_latched // Latched
);
	import efsup_pkg::*;
	localparam logic [15:0] TO_LIM = 16'(SHARED_SWITCH_ENABLE_TO_CYC + 4);
	logic [15:0] low_q;
	// Counts cycles the line has stayed low
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			low_q <= 16'h0000;
		else if (i_shared_switch_enable)
			low_q <= 16'h0000;
		else if (low_q != 16'hFFFF)
			low_q <= low_q + 16'h0001;
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_trip;
		o_secondary_mode && o_gate_on && $rose(i_sense.fast_trip);
	endsequence
	a_line_off: assert property (!i_shared_switch_enable [*3] |-> !o_gate_on)
		else $error("gate on with line low");
	a_tsd_line: assert property (o_thermal_shutdown [*2] |-> o_shared_switch_enable_oe)
		else $error("line free in shutdown");
	a_tsd_enter: assert property ($rose(i_sense.tj_over_tsd) && !o_fault_latched
		&& i_supply.supply_ok && i_supply.en_above_sd |-> ##[2:6] o_thermal_shutdown)
		else $error("no thermal shutdown");
	a_fault_pin: assert property ((o_fault_latched && !o_secondary_mode) [*3]
		|-> o_fault_out_n_oe) else $error("fault pin not driven");
	a_fault_gate: assert property (o_fault_latched && !o_secondary_mode |-> !o_gate_on)
		else $error("gate on with fault");
	a_fault_clear: assert property (!i_supply.en_above_sd [*5]
		|-> !o_fault_latched && !o_fault_out_n_oe) else $error("fault not cleared");
	a_uvlo_keep: assert property ((!AUTO_RETRY && !o_secondary_mode && o_fault_latched
		&& i_supply.en_above_sd && i_supply.supply_ok) [*3] |=> o_fault_latched)
		else $error("fault lost");
	a_shake_pull: assert property (s_trip |-> ##[2:6] o_shared_switch_enable_oe)
		else $error("no pull after trip");
	a_shake_pin: assert property (s_trip |-> !o_fault_out_n_oe [*8])
		else $error("fault pin after trip");
	a_fast_clear: assert property (low_q > TO_LIM |-> !o_fast_recovery_flag)
		else $error("fast flag kept");
endmodule
bind efsup_core efsup_chk #(.AUTO_RETRY(AUTO_RETRY), .SHARED_SWITCH_ENABLE_TO_CYC(SHARED_SWITCH_ENABLE_TO_CYC)) u_efsup_chk (
	.i_ref_clk, .i_sys_rst, .i_supply, .i_sense, .i_shared_switch_enable,
	.o_shared_switch_enable_oe, .o_gate_on, .o_fault_out_n_oe, .o_fast_recovery_flag,
	.o_thermal_shutdown, .o_secondary_mode, .o_fault_latched);
`default_nettype wire

// ===== verification/efsup_prim_model.sv
// Primary fuse and pull-up on the shared enable line
`timescale 1ns/1ps
`default_nettype none
module efsup_prim_model (
	input wire logic i_ref_clk, // Clock
	input wire logic i_sys_rst, // Reset
	input wire logic i_dut_pull, // Secondary pulls low
	input wire logic i_react, // Primary registers faults
	input wire logic i_hold, // Primary pulls low itself
	output logic o_line // Resolved line
);
	logic take_q;
	// Takes over the pull one cycle after the secondary signals
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			take_q <= 1'b0;
		else
			take_q <= i_react && (take_q || i_dut_pull);
	end
	assign o_line = !(i_dut_pull || take_q || i_hold);
endmodule
`default_nettype wire

// ===== verification/tb_efuse_fault_sync_supervisor.sv
// Self-checking bench for the fuse supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_efuse_fault_sync_supervisor;
	import efsup_pkg::*;
	localparam efsup_supply_t SUP_OK = 5'h1C;
	localparam efsup_sense_t SEN_OK = 14'h0540;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mode = 1'b0;
	logic react = 1'b0;
	logic hold = 1'b0;
	efsup_supply_t sup = SUP_OK;
	efsup_sense_t sen = SEN_OK;
	logic line, oe, gate, dis, fon, frec, thermal_shutdown_threshold, smode, flt, sdat, fdat;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	efsup_core #(.DS_TMR_CYC(20), .SU_TMR_CYC(20), .RETRY_CYC(20), .SHARED_SWITCH_ENABLE_TO_CYC(20),
		.BKP_TMR_CYC(20)) u_efsup_core (.i_ref_clk(clk), .i_sys_rst(rst),
		.i_mode_secondary(mode), .i_supply(sup), .i_sense(sen), .i_shared_switch_enable(line),
		.o_shared_switch_enable(sdat), .o_shared_switch_enable_oe(oe), .o_gate_on(gate),
		.o_output_discharge(dis), .o_fault_out_n(fdat), .o_fault_out_n_oe(fon),
		.o_fast_recovery_flag(frec), .o_thermal_shutdown(thermal_shutdown_threshold), .o_secondary_mode(smode),
		.o_fault_latched(flt));
	efsup_prim_model u_efsup_prim_model (.i_ref_clk(clk), .i_sys_rst(rst), .i_dut_pull(oe),
		.i_react(react), .i_hold(hold), .o_line(line));
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			err_total++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input logic seen, input logic exp, input string msg);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	task automatic do_reset(input logic m);
		rst <= 1'b1;
		mode <= m;
		sup <= SUP_OK;
		sen <= SEN_OK;
		tick(10);
		rst <= 1'b0;
		tick(30);
	endtask
	task automatic clear_en();
		sup.en_above_sd <= 1'b0;
		tick(6);
		sup <= SUP_OK;
		tick(30);
	endtask
	task automatic t_gs();
		chk(smode, 1'b0, "mode");
		chk(gate, 1'b1, "no start");
		chk(sdat || fdat, 1'b0, "open-drain level");
		chk(frec, 1'b1, "fast flag");
		sen.gate_overdrive_ok <= 1'b0;
		tick(6);
		chk(flt, 1'b1, "no latch");
		chk(oe, 1'b1, "line free");
		sen.gate_overdrive_ok <= 1'b1;
		sup.en_above_uvlo <= 1'b0;
		tick(30);
		chk(flt, 1'b1, "uvlo cleared");
		chk(frec, 1'b0, "fast flag");
		clear_en();
		chk(fon, 1'b0, "fault pin");
		chk(gate, 1'b1, "no restart");
		$display("gate test done");
	endtask
	task automatic t_tsd(input logic rel);
		sen.tj_over_tsd <= !rel;
		sen.tj_below_exit <= rel;
		sen.rel_over <= rel;
		sen.rel_below <= !rel;
		tick(6);
		chk(thermal_shutdown_threshold, 1'b1, "no shutdown");
		sen <= SEN_OK;
		tick(40);
		chk(gate, 1'b0, "left latch");
		chk(fon, 1'b1, "fault pin");
		sup.supply_ok <= 1'b0;
		tick(6);
		sup <= SUP_OK;
		tick(30);
		chk(gate, 1'b1, "no restart");
		$display("thermal test done");
	endtask
	task automatic t_ext();
		hold <= 1'b1;
		tick(6);
		chk(flt, 1'b1, "no ext fault");
		hold <= 1'b0;
		clear_en();
		chk(gate, 1'b1, "no restart");
		$display("ext test done");
	endtask
	task automatic t_ds();
		sup.en_above_uvlo <= 1'b0;
		sen.vds_below_dsok <= 1'b1;
		tick(6);
		sup.en_above_uvlo <= 1'b1;
		tick(8);
		chk(dis, 1'b1, "no discharge");
		chk(gate, 1'b0, "gate on");
		tick(30);
		chk(flt, 1'b1, "no ds fault");
		chk(fon, 1'b1, "fault pin");
		sen.vds_below_dsok <= 1'b0;
		clear_en();
		$display("ds test done");
	endtask
	task automatic t_sec(input logic ok);
		react <= ok;
		sen.fast_trip <= 1'b1;
		tick(2);
		sen.fast_trip <= 1'b0;
		tick(6);
		chk(oe, 1'b1, "no pull");
		chk(fon, 1'b0, "fault pin");
		tick(110);
		if (ok)
			chk(oe, 1'b0, "no release");
		else
			chk(oe, 1'b1, "line free");
		chk(flt, !ok, "fault state");
		chk(gate, 1'b0, "gate on");
		react <= 1'b0;
		tick(30);
		chk(gate, ok, "line follow");
		if (!ok)
			clear_en();
		chk(gate, 1'b1, "no restart");
		$display("secondary test done");
	endtask
	task automatic t_hw();
		sen.fast_trip <= 1'b1;
		tick(6);
		chk(flt, 1'b1, "no trip latch");
		chk(fon, 1'b1, "fault pin");
		sen.fast_trip <= 1'b0;
		clear_en();
		sen.timer_pin_high <= 1'b1;
		sen.over_ocp <= 1'b1;
		tick(12);
		chk(flt, 1'b0, "early backup");
		tick(20);
		chk(flt, 1'b1, "no backup latch");
		sen <= SEN_OK;
		clear_en();
		sup.en_above_uvlo <= 1'b0;
		sen.gate_near_vin <= 1'b1;
		tick(8);
		chk(flt, 1'b1, "no gate-drain fault");
		sen.gate_near_vin <= 1'b0;
		sen.gate_overdrive_ok <= 1'b0;
		clear_en();
		tick(10);
		chk(flt, 1'b1, "no startup timeout");
		sen <= SEN_OK;
		clear_en();
		chk(gate, 1'b1, "no restart");
		$display("health test done");
	endtask
	initial begin
		do_reset(1'b0);
		t_gs();
		t_tsd(1'b0);
		t_tsd(1'b1);
		t_ext();
		t_ds();
		t_hw();
		do_reset(1'b1);
		chk(smode, 1'b1, "mode");
		t_sec(1'b1);
		t_sec(1'b0);
		close_out();
	end
endmodule
`default_nettype wire
